// ### logic/rtca_pkg.sv
// Purpose: Constants and types for the dual alarm compare and interrupt block
// Assumes: 200 MHz REF_CLK, time bytes supplied by same-clock calendar logic
// Notes:   Alarm bytes sit at CCR offsets 0x00..0x0f, eight per alarm set
//
// Behaviour
// - Compare each alarm set against the live time and calendar bytes.
// - A match sets that alarm's status flag, interrupt enabled or not.
// - Both flags clear on the eighth falling SCL of a status read.
// - Single-event mode: alarm enable 1, repeat select 0, frequency output off.
// - Single-event mode pulls the interrupt low until the flag is read.
// - Either alarm asserts the pin; it must clear before re-asserting.
// - Pulsed mode: enable 1, repeat select 1, frequency off, pulse per match.
// - Both enables in pulsed mode pulse the shared pin for each alarm.
// - Pulsed mode continues until repeat select or enables are cleared.
// - Single-byte writes to either weekday alarm byte never commit.
// - A write ending on an alarm set's highest byte never commits.
// - Commit only when the final byte lies in 0x00-0x04 or 0x08-0x0c.
// - The alarm address counter wraps from 0x0f back to 0x00.
// - Two-bit select: 00 alarm output, other codes a fixed frequency.
// - A committed nonvolatile write runs an internal cycle up to 20 ms.
package rtca_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ         = 200;
  localparam int NV_WRITE_MS     = 20;
  localparam int NV_WRITE_CYCLES = NV_WRITE_MS * 1000 * CLK_MHZ;
  localparam int PULSE_NS        = 1000;
  localparam int PULSE_CYCLES    = (PULSE_NS * CLK_MHZ) / 1000;

  // ****************************************
  // Bus address and register map
  // ****************************************
  localparam logic [6:0] CCR_DEV_ADDR        = 7'h6f;
  localparam logic [7:0] ALARM0_SECONDS_OFS  = 8'h00;
  localparam logic [7:0] ALARM0_MINUTES_OFS  = 8'h01;
  localparam logic [7:0] ALARM0_WEEKDAY_OFS  = 8'h06;
  localparam logic [7:0] ALARM0_CENTURY_OFS  = 8'h07;
  localparam logic [7:0] ALARM1_SECONDS_OFS  = 8'h08;
  localparam logic [7:0] ALARM1_WEEKDAY_OFS  = 8'h0e;
  localparam logic [7:0] ALARM_LAST_OFS      = 8'h0f;
  localparam logic [7:0] INT_CTRL_OFS        = 8'h11;
  localparam logic [7:0] STATUS_BYTE_OFS     = 8'h3f;
  localparam logic [3:0] COMMIT0_LO          = 4'h0;
  localparam logic [3:0] COMMIT0_HI          = 4'h4;
  localparam logic [3:0] COMMIT1_LO          = 4'h8;
  localparam logic [3:0] COMMIT1_HI          = 4'hc;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int SR_NV_BUSY_BIT       = 0;
  localparam int SR_ALARM_ZERO_BIT    = 5;
  localparam int SR_ALARM_ONE_BIT     = 6;
  localparam int FIELD_EN_BIT         = 7;
  localparam int ALARM_FIELDS         = 7;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] ALARM_RESET  = 8'h00;
  localparam logic [1:0] FSEL_ALARM   = 2'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [7:0] century;
    logic [7:0] weekday;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } rtca_time_t;

  typedef struct packed {
    logic       repeat_interrupt_select;
    logic       alarm_one_enable;
    logic       alarm_zero_enable;
    logic [2:0] unused;
    logic       freq_select_high;
    logic       freq_select_low;
  } rtca_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RECV = 3'h1,
    ST_ACK  = 3'h3,
    ST_SEND = 3'h2,
    ST_RACK = 3'h6
  } rtca_state_t;

endpackage

// ### logic/rtca_match.sv
// Purpose: Compare one alarm set with the running time, pulse on a new match
// Assumes: Field enable in bit 7 of each alarm byte, value in bits 6:0
// Notes:   Century byte takes no part in the compare
`timescale 1ns/1ps
module rtca_match
  import rtca_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [63:0] alarm_bytes,
  input  wire logic [63:0] time_bytes,
  output logic             match_pulse
);

  logic [ALARM_FIELDS-1:0] field_en;
  logic [ALARM_FIELDS-1:0] field_ok;
  logic                    match_now;
  logic                    match_reg;

  // ****************************************
  // Per-field compare
  // ****************************************
  for (genvar f = 0; f < ALARM_FIELDS; f++) begin : g_field
    assign field_en[f] = alarm_bytes[8*f+FIELD_EN_BIT];
    assign field_ok[f] = !field_en[f] ||
                         (alarm_bytes[8*f +: 7] == time_bytes[8*f +: 7]);
  end

  // A set with no field enabled never matches
  assign match_now = (|field_en) && (&field_ok);

  // ****************************************
  // Edge of match
  // ****************************************
  // Edge, not level: the match holds a whole second or more
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      match_reg   <= 1'b0;
      match_pulse <= 1'b0;
    end else begin
      match_reg   <= match_now;
      match_pulse <= match_now && !match_reg;
    end
  end

endmodule

// ### logic/rtca_top.sv
// Purpose: Dual alarm, status flags, interrupt pin and alarm commit control
// Assumes: Two-wire bus pins are asynchronous; time and taps share REF_CLK
// Notes:   Alarm writes are staged and only reach the alarm bytes on commit
`timescale 1ns/1ps
module rtca_top
  import rtca_pkg::*;
#(
  parameter int NV_CYCLES    = NV_WRITE_CYCLES,
  parameter int PULSE_WIDTH  = PULSE_CYCLES
)(
  input  wire logic       REF_CLK,
  input  wire logic       RST_N,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  input  wire rtca_time_t TIME_NOW,
  input  wire logic [2:0] FREQ_TAPS,
  output logic            IRQ_OUT,
  output logic            IRQ_OE,
  output logic            NV_BUSY
);

  if (NV_CYCLES < 1 || PULSE_WIDTH < 1 || PULSE_WIDTH > 65535) begin : g_chk
    $error("rtca_top: cycle counts must be at least one");
  end

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic commit_ok(input logic [3:0] a);
    commit_ok = (a >= COMMIT0_LO && a <= COMMIT0_HI) ||
                (a >= COMMIT1_LO && a <= COMMIT1_HI);
  endfunction

  function automatic logic is_alarm(input logic [7:0] a);
    is_alarm = (a <= ALARM_LAST_OFS);
  endfunction

  // ****************************************
  // Pin synchronisers and bus conditions
  // ****************************************
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], SCL_IN};
      sda_sync_reg <= {sda_sync_reg[0], SDA_IN};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end

  assign scl_rise  = scl_sync_reg[1] && !scl_d_reg;
  assign scl_fall  = !scl_sync_reg[1] && scl_d_reg;
  assign bus_start = scl_sync_reg[1] && scl_d_reg && sda_d_reg && !sda_sync_reg[1];
  assign bus_stop  = scl_sync_reg[1] && scl_d_reg && !sda_d_reg && sda_sync_reg[1];

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0]  alarm_reg [16];
  logic [7:0]  stage_reg [16];
  logic [15:0] dirty_reg;
  logic [63:0] alarm0_bytes;
  logic [63:0] alarm1_bytes;
  rtca_ctrl_t  ctrl_reg;
  logic        flag0_reg;
  logic        flag1_reg;
  logic        busy_reg;
  logic [31:0] busy_cnt_reg;

  for (genvar i = 0; i < 8; i++) begin : g_pack
    assign alarm0_bytes[8*i +: 8] = alarm_reg[i];
    assign alarm1_bytes[8*i +: 8] = alarm_reg[i+8];
  end

  // ****************************************
  // Bus slave state
  // ****************************************
  rtca_state_t state_reg;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [1:0]  phase_reg;
  logic        rd_reg;
  logic        mack_reg;
  logic [7:0]  addr_reg;
  logic [3:0]  last_reg;
  logic        wrote_alarm_reg;
  logic        wrote_ctrl_reg;
  logic        sda_oe_reg;
  logic        sda_out_reg;
  logic [7:0]  rd_byte;
  logic [7:0]  rx_byte;
  logic [7:0]  addr_next;
  logic        wr_strobe;
  logic        status_read_done;
  logic        commit_go;

  assign rx_byte = {shift_reg[6:0], sda_sync_reg[1]};

  assign addr_next = is_alarm(addr_reg) ? {4'h0, addr_reg[3:0] + 4'h1}
                                        : addr_reg + 8'h01;

  always_comb begin
    rd_byte = 8'h00;
    if (is_alarm(addr_reg)) begin
      rd_byte = alarm_reg[addr_reg[3:0]];
    end else if (addr_reg == INT_CTRL_OFS) begin
      rd_byte = ctrl_reg;
    end else if (addr_reg == STATUS_BYTE_OFS) begin
      rd_byte[SR_ALARM_ZERO_BIT] = flag0_reg;
      rd_byte[SR_ALARM_ONE_BIT]  = flag1_reg;
      rd_byte[SR_NV_BUSY_BIT]    = busy_reg;
    end
  end

  assign wr_strobe = (state_reg == ST_RECV) && scl_fall && bit_cnt_reg == 4'h8 &&
                     phase_reg == 2'h3;
  // Eighth falling clock of a data byte sent from the status offset
  assign status_read_done = (state_reg == ST_SEND) && scl_fall && bit_cnt_reg == 4'h7 &&
                            addr_reg == STATUS_BYTE_OFS;
  assign commit_go = bus_stop && wrote_alarm_reg && commit_ok(last_reg);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      phase_reg   <= 2'h0;
      rd_reg      <= 1'b0;
      mack_reg    <= 1'b0;
      addr_reg    <= 8'h00;
      sda_oe_reg  <= 1'b0;
    end else if (bus_start) begin
      state_reg   <= ST_RECV;
      bit_cnt_reg <= 4'h0;
      phase_reg   <= 2'h0;
      sda_oe_reg  <= 1'b0;
    end else if (bus_stop) begin
      state_reg   <= ST_IDLE;
      sda_oe_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        ST_RECV: begin
          if (scl_rise && bit_cnt_reg != 4'h8) begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            // Busy with a nonvolatile cycle: no answer at all
            if (phase_reg == 2'h0 && (shift_reg[7:1] != CCR_DEV_ADDR || busy_reg)) begin
              state_reg <= ST_IDLE;
            end else begin
              state_reg  <= ST_ACK;
              sda_oe_reg <= 1'b1;
              unique case (phase_reg)
                2'h0: rd_reg <= shift_reg[0];
                2'h1: ;
                2'h2: addr_reg <= shift_reg;
                2'h3: addr_reg <= addr_next;
              endcase
              if (phase_reg != 2'h3) begin
                phase_reg <= phase_reg + 2'h1;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rd_reg && phase_reg == 2'h1) begin
              state_reg  <= ST_SEND;
              shift_reg  <= rd_byte;
              sda_oe_reg <= !rd_byte[7];
            end else begin
              state_reg  <= ST_RECV;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            shift_reg   <= {shift_reg[6:0], 1'b0};
            if (bit_cnt_reg == 4'h7) begin
              state_reg  <= ST_RACK;
              sda_oe_reg <= 1'b0;
              addr_reg   <= addr_next;
            end else begin
              sda_oe_reg <= !shift_reg[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            mack_reg <= !sda_sync_reg[1];
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (mack_reg) begin
              state_reg  <= ST_SEND;
              shift_reg  <= rd_byte;
              sda_oe_reg <= !rd_byte[7];
            end else begin
              state_reg <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sda_out_reg <= 1'b0;
    end else begin
      sda_out_reg <= 1'b0;
    end
  end

  // ****************************************
  // Staging and commit of alarm bytes
  // ****************************************
  // Staged bytes that fail the commit test are dropped at stop
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < 16; i++) begin
        stage_reg[i] <= ALARM_RESET;
        alarm_reg[i] <= ALARM_RESET;
      end
      dirty_reg       <= 16'h0000;
      last_reg        <= 4'h0;
      wrote_alarm_reg <= 1'b0;
    end else if (bus_start || bus_stop) begin
      for (int i = 0; i < 16; i++) begin
        if (commit_go && dirty_reg[i]) begin
          alarm_reg[i] <= stage_reg[i];
        end
      end
      dirty_reg       <= 16'h0000;
      wrote_alarm_reg <= 1'b0;
    end else if (wr_strobe && is_alarm(addr_reg)) begin
      stage_reg[addr_reg[3:0]] <= shift_reg;
      dirty_reg[addr_reg[3:0]] <= 1'b1;
      last_reg                 <= addr_reg[3:0];
      wrote_alarm_reg          <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg       <= CTRL_RESET;
      wrote_ctrl_reg <= 1'b0;
    end else if (wr_strobe && addr_reg == INT_CTRL_OFS) begin
      ctrl_reg       <= shift_reg;
      wrote_ctrl_reg <= 1'b1;
    end else if (bus_start || bus_stop) begin
      wrote_ctrl_reg <= 1'b0;
    end
  end

  // Inputs are ignored while busy, so no start can abort the cycle
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_reg     <= 1'b0;
      busy_cnt_reg <= 32'h0000_0000;
    end else if (commit_go || (bus_stop && wrote_ctrl_reg)) begin
      busy_reg     <= 1'b1;
      busy_cnt_reg <= 32'(NV_CYCLES - 1);
    end else if (busy_reg) begin
      if (busy_cnt_reg == 32'h0000_0000) begin
        busy_reg <= 1'b0;
      end else begin
        busy_cnt_reg <= busy_cnt_reg - 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // Alarm compare and status flags
  // ****************************************
  logic match0;
  logic match1;

  rtca_match u_match0 (
    .clk         (REF_CLK),
    .rst_n       (RST_N),
    .alarm_bytes (alarm0_bytes),
    .time_bytes  (TIME_NOW),
    .match_pulse (match0)
  );

  rtca_match u_match1 (
    .clk         (REF_CLK),
    .rst_n       (RST_N),
    .alarm_bytes (alarm1_bytes),
    .time_bytes  (TIME_NOW),
    .match_pulse (match1)
  );

  // Set beats clear when a match lands on the clearing edge
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flag0_reg <= 1'b0;
      flag1_reg <= 1'b0;
    end else begin
      flag0_reg <= match0 || (flag0_reg && !status_read_done);
      flag1_reg <= match1 || (flag1_reg && !status_read_done);
    end
  end

  // ****************************************
  // Interrupt and frequency pin
  // ****************************************
  logic        freq_mode;
  logic        evt;
  logic        latch_reg;
  logic [15:0] pulse_cnt_reg;
  logic        pin_low_reg;
  logic        busy_out_reg;

  assign freq_mode = {ctrl_reg.freq_select_high, ctrl_reg.freq_select_low} != FSEL_ALARM;
  assign evt = !freq_mode && ((match0 && ctrl_reg.alarm_zero_enable) ||
                              (match1 && ctrl_reg.alarm_one_enable));

  // Single event: latch until the flag read; later matches are held off
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      latch_reg <= 1'b0;
    end else if (freq_mode || ctrl_reg.repeat_interrupt_select) begin
      latch_reg <= 1'b0;
    end else if (evt) begin
      latch_reg <= 1'b1;
    end else if (status_read_done) begin
      latch_reg <= 1'b0;
    end
  end

  // Pulsed: width fixed, cut short only by mode or enables dropping
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pulse_cnt_reg <= 16'h0000;
    end else if (freq_mode || !ctrl_reg.repeat_interrupt_select ||
                 !(ctrl_reg.alarm_zero_enable || ctrl_reg.alarm_one_enable)) begin
      pulse_cnt_reg <= 16'h0000;
    end else if (evt) begin
      pulse_cnt_reg <= 16'(PULSE_WIDTH);
    end else if (pulse_cnt_reg != 16'h0000) begin
      pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_low_reg  <= 1'b0;
      busy_out_reg <= 1'b0;
    end else begin
      unique case ({ctrl_reg.freq_select_high, ctrl_reg.freq_select_low})
        2'h0: pin_low_reg <= latch_reg || (pulse_cnt_reg != 16'h0000);
        2'h1: pin_low_reg <= !FREQ_TAPS[0];
        2'h2: pin_low_reg <= !FREQ_TAPS[1];
        2'h3: pin_low_reg <= !FREQ_TAPS[2];
      endcase
      busy_out_reg <= busy_reg;
    end
  end

  assign SDA_OUT = sda_out_reg;
  assign SDA_OE  = sda_oe_reg;
  assign IRQ_OUT = sda_out_reg;
  assign IRQ_OE  = pin_low_reg;
  assign NV_BUSY = busy_out_reg;

endmodule

// ### tb/rtca_chk.sv
// Purpose: Port-level assertions for the dual alarm block
// Assumes: Bus clock halves last eight or more REF_CLK cycles, taps held six or more
// Notes:   Pin widths are only measurable because the taps change slowly
`timescale 1ns/1ps
module rtca_chk
  import rtca_pkg::*;
#(
  parameter int NV_CYCLES   = 50,
  parameter int PULSE_WIDTH = 4
)(
  input wire logic       REF_CLK,
  input wire logic       RST_N,
  input wire logic       SCL_IN,
  input wire logic       SDA_IN,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE,
  input wire rtca_time_t TIME_NOW,
  input wire logic [2:0] FREQ_TAPS,
  input wire logic       IRQ_OUT,
  input wire logic       IRQ_OE,
  input wire logic       NV_BUSY
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic [31:0] busy_cnt_reg;
  logic [31:0] hi_cnt_reg;
  logic [7:0]  evt_hist_reg;
  logic [7:0]  stop_hist_reg;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) busy_cnt_reg <= '0;
    else busy_cnt_reg <= NV_BUSY ? busy_cnt_reg + 32'h1 : 32'h0;
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) hi_cnt_reg <= '0;
    else hi_cnt_reg <= IRQ_OE ? hi_cnt_reg + 32'h1 : 32'h0;
  end
  // A time, tap or SCL change may explain a pin edge; a control write arrives on SCL
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) evt_hist_reg <= '0;
    else evt_hist_reg <= {evt_hist_reg[6:0],
                          $changed(TIME_NOW) || $changed(FREQ_TAPS) || $changed(SCL_IN)};
  end
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) stop_hist_reg <= '0;
    else stop_hist_reg <= {stop_hist_reg[6:0], SCL_IN && SDA_IN && !$past(SDA_IN)};
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_busy_run;
    NV_BUSY [*8];
  endsequence
  sequence s_stop_seen;
    stop_hist_reg != 8'h00;
  endsequence

  a_sda_out_low: assert property (SDA_OUT == 1'b0)
    else $error("SDA_OUT not low");
  a_irq_out_low: assert property (IRQ_OUT == 1'b0)
    else $error("IRQ_OUT not low");
  a_busy_exact_len: assert property ($fell(NV_BUSY) |-> busy_cnt_reg == NV_CYCLES)
    else $error("busy length wrong");
  a_busy_upper_bound: assert property (busy_cnt_reg <= NV_CYCLES)
    else $error("busy too long");
  a_busy_hold_run: assert property ($rose(NV_BUSY) |-> s_busy_run)
    else $error("busy dropped early");
  a_busy_no_ack: assert property (NV_BUSY |-> !SDA_OE)
    else $error("SDA driven while busy");
  a_commit_after_stop: assert property ($rose(NV_BUSY) |-> s_stop_seen)
    else $error("busy without stop");
  a_sda_scl_low: assert property ($changed(SDA_OE) |-> !$past(SCL_IN, 2))
    else $error("SDA changed with SCL high");
  a_irq_min_width: assert property ($fell(IRQ_OE) |-> hi_cnt_reg >= PULSE_WIDTH)
    else $error("interrupt pulse too short");
  a_irq_has_cause: assert property ($rose(IRQ_OE) |-> evt_hist_reg != 8'h00)
    else $error("interrupt without event");
endmodule

bind rtca_top rtca_chk #(.NV_CYCLES(NV_CYCLES), .PULSE_WIDTH(PULSE_WIDTH)) i_chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .TIME_NOW(TIME_NOW), .FREQ_TAPS(FREQ_TAPS),
  .IRQ_OUT(IRQ_OUT), .IRQ_OE(IRQ_OE), .NV_BUSY(NV_BUSY));

// ### tb/rtca_host.sv
// Purpose: Two-wire host model for register access
// Assumes: Line is open drain with pull-up, wired-AND formed by the bench
// Notes:   Slow bit timing keeps the device synchroniser well inside margins
`timescale 1ns/1ps
module rtca_host
  import rtca_pkg::*;
(
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl_drv,
  output logic      sda_drv
);
  localparam int HOLD = 8;
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hold;
    repeat (HOLD) @(negedge clk);
  endtask
  task automatic clock_bit(input logic v, output logic s);
    sda_drv = v;
    hold();
    scl_drv = 1'b1;
    hold();
    s = sda_line;
    scl_drv = 1'b0;
    hold();
  endtask
  task automatic start;
    sda_drv = 1'b1;
    hold();
    scl_drv = 1'b1;
    hold();
    sda_drv = 1'b0;
    hold();
    scl_drv = 1'b0;
    hold();
  endtask
  task automatic stop;
    sda_drv = 1'b0;
    hold();
    scl_drv = 1'b1;
    hold();
    sda_drv = 1'b1;
    hold();
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
    clock_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic get(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      b[i] = s;
    end
    clock_bit(last, s);
  endtask
  task automatic write(input logic [7:0] a, input int n, input logic [7:0] d [16],
                       output logic ok);
    logic ack;
    start();
    put({CCR_DEV_ADDR, 1'b0}, ok);
    put(8'h00, ack);
    put(a, ack);
    for (int i = 0; i < n; i++) put(d[i], ack);
    stop();
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] b, output logic ok);
    logic ack;
    start();
    put({CCR_DEV_ADDR, 1'b0}, ok);
    put(8'h00, ack);
    put(a, ack);
    start();
    put({CCR_DEV_ADDR, 1'b1}, ack);
    get(1'b1, b);
    stop();
  endtask
endmodule

// ### tb/testbench.sv
// Purpose: Directed checks of alarm flags, interrupt pin and commit rules
// Assumes: Shortened busy and pulse counts, time bytes driven by the bench
// Notes:   Every commit is waited out, since the device refuses while busy
`timescale 1ns/1ps
module testbench;
  import rtca_pkg::*;
  localparam int NV = 50;
  localparam int PW = 4;
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       scl, host_sda, sda_out, sda_oe, irq_out, irq_oe, nv_busy;
  wire        sda_line = host_sda & ~sda_oe;
  rtca_time_t time_now = '0;
  logic [2:0] taps = 3'h0;
  int         bad_count = 0;
  int         num_checks = 0;
  logic [7:0] d [16];
  logic [7:0] rd, n;
  logic       ok;

  always #2.5 ref_clk = ~ref_clk;

  rtca_top #(.NV_CYCLES(NV), .PULSE_WIDTH(PW)) i_dut (
    .REF_CLK(ref_clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda_line),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .TIME_NOW(time_now), .FREQ_TAPS(taps),
    .IRQ_OUT(irq_out), .IRQ_OE(irq_oe), .NV_BUSY(nv_busy));
  rtca_host i_host (.clk(ref_clk), .sda_line(sda_line), .scl_drv(scl), .sda_drv(host_sda));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_byte(what, {7'h0, exp}, {7'h0, got});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wait_idle;
    int i;
    i = 0;
    repeat (8) @(negedge ref_clk);
    while (nv_busy !== 1'b0 && i < 4 * NV) begin
      @(negedge ref_clk);
      i++;
    end
    chk_bit("nv busy idle", 1'b0, nv_busy);
    if (nv_busy !== 1'b0) test_done();
  endtask
  task automatic set_ctrl(input logic [7:0] v);
    d[0] = v;
    i_host.write(INT_CTRL_OFS, 1, d, ok);
    wait_idle();
  endtask
  // Present a time for four cycles and count cycles with the pin active
  task automatic count_irq(input logic [7:0] sec);
    n = 8'h00;
    time_now.seconds = sec;
    for (int i = 0; i < 24; i++) begin
      @(negedge ref_clk);
      if (i == 3) time_now.seconds = 8'h00;
      if (irq_oe === 1'b1) n = n + 8'h01;
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_nv(input logic [7:0] a, input int cnt, input logic [7:0] seed,
                      input logic commit, input logic [7:0] ca, input logic [7:0] cv);
    for (int i = 0; i < 16; i++) d[i] = seed + 8'(i);
    i_host.write(a, cnt, d, ok);
    chk_bit("write ack", 1'b1, ok);
    repeat (6) @(negedge ref_clk);
    chk_bit("nv busy", commit, nv_busy);
    wait_idle();
    i_host.read(ca, rd, ok);
    chk_byte("alarm byte", cv, rd);
    $display("t_nv at %h done", a);
  endtask
  task automatic t_reset;
    chk_bit("irq pin", 1'b0, irq_oe);
    chk_bit("nv busy", 1'b0, nv_busy);
    i_host.read(STATUS_BYTE_OFS, rd, ok);
    chk_byte("status", 8'h00, rd);
    i_host.read(ALARM0_SECONDS_OFS, rd, ok);
    chk_byte("alarm0 seconds", ALARM_RESET, rd);
    $display("t_reset done");
  endtask
  task automatic t_flag;
    for (int i = 0; i < 16; i++) d[i] = 8'h00;
    d[7] = 8'hb0;
    d[15] = 8'h95;
    i_host.write(ALARM0_MINUTES_OFS, 16, d, ok);
    wait_idle();
    count_irq(8'h15);
    chk_byte("irq count", 8'h00, n);
    i_host.read(STATUS_BYTE_OFS, rd, ok);
    chk_byte("status", 8'h20, rd);
    i_host.read(STATUS_BYTE_OFS, rd, ok);
    chk_byte("status", 8'h00, rd);
    $display("t_flag done");
  endtask
  task automatic t_single;
    set_ctrl(8'h20);
    count_irq(8'h15);
    chk_bit("irq pin", 1'b1, irq_oe);
    count_irq(8'h30);
    chk_byte("irq count", 8'h18, n);
    i_host.read(STATUS_BYTE_OFS, rd, ok);
    chk_byte("status", 8'h60, rd);
    chk_bit("irq pin", 1'b0, irq_oe);
    count_irq(8'h15);
    chk_bit("irq pin", 1'b1, irq_oe);
    i_host.read(STATUS_BYTE_OFS, rd, ok);
    $display("t_single done");
  endtask
  task automatic t_pulse;
    set_ctrl(8'he0);
    count_irq(8'h15);
    chk_byte("pulse width", 8'(PW), n);
    count_irq(8'h30);
    chk_byte("pulse width", 8'(PW), n);
    count_irq(8'h15);
    chk_byte("pulse width", 8'(PW), n);
    set_ctrl(8'h80);
    count_irq(8'h15);
    chk_byte("irq count", 8'h00, n);
    i_host.read(STATUS_BYTE_OFS, rd, ok);
    chk_byte("status", 8'h60, rd);
    $display("t_pulse done");
  endtask
  task automatic t_freq;
    set_ctrl(8'h21);
    chk_bit("tap level", 1'b1, irq_oe);
    count_irq(8'h15);
    chk_byte("irq count", 8'h18, n);
    taps = 3'h1;
    repeat (6) @(negedge ref_clk);
    chk_bit("tap level", 1'b0, irq_oe);
    taps = 3'h6;
    repeat (6) @(negedge ref_clk);
    chk_bit("tap level", 1'b1, irq_oe);
    $display("t_freq done");
  endtask

  initial begin
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_reset();
    t_nv(8'h00, 1, 8'h95, 1'b1, 8'h00, 8'h95);
    t_nv(8'h06, 1, 8'h11, 1'b0, 8'h06, ALARM_RESET);
    t_nv(8'h06, 3, 8'h21, 1'b1, 8'h06, 8'h21);
    t_nv(8'h05, 3, 8'h41, 1'b0, 8'h05, ALARM_RESET);
    t_nv(8'h09, 16, 8'h61, 1'b1, 8'h08, 8'h70);
    t_nv(8'h0e, 1, 8'h12, 1'b0, 8'h0e, 8'h66);
    t_nv(8'h01, 16, 8'h81, 1'b1, 8'h00, 8'h90);
    t_flag();
    t_single();
    t_pulse();
    t_freq();
    test_done();
  end
endmodule
